//--- src/rpv_top.sv
// What this block does
// - Protection fixed at build, never changeable
// - Mode 1 drives addressed byte out
// - Mode 2 compares internally, never drives ROM onto port 0
// - Pass/fail reported after every 16 bytes
// - Outside code reads of protected ROM invalid
// - 14-bit address in, byte out later
// - Mode 2 starts at reset release
// - Strobe every three clocks, pointer increments
// - Sample three clocks after strobe, compare
// - Group result held static during next group
module rpv_top
    import rpv_pkg::*;
#(
    parameter bit PROTECTED = 1'b1
)(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire rpv_sel_t          sel_i,
    input  wire logic [ADDR_W-1:0] test_addr_i,
    input  wire logic [DATA_W-1:0] port0_i,
    input  wire logic              code_move_ext_i,
    input  wire logic [ADDR_W-1:0] code_move_addr_i,
    output logic      [DATA_W-1:0] port0_o,
    output logic                   port0_oe_o,
    output logic                   ale_o,
    output logic                   program_store_strobe_o,
    output logic                   verify_result_pin_o,
    output logic      [DATA_W-1:0] code_move_data_o
);
    // Pin synchronisers, two stages each
    rpv_sel_t          sel_s1, sel_s2;
    logic [ADDR_W-1:0] addr_s1, addr_s2;
    logic [DATA_W-1:0] p0_s1, p0_s2;
    logic              rst_s1, rst_s2;

    always_ff @(posedge ref_clk_i) begin
        sel_s1  <= sel_i;
        sel_s2  <= sel_s1;
        addr_s1 <= test_addr_i;
        addr_s2 <= addr_s1;
        p0_s1   <= port0_i;
        p0_s2   <= p0_s1;
        rst_s1  <= rst_i;
        rst_s2  <= rst_s1;
    end

    function automatic logic sel_is(input rpv_sel_t s, input logic st, input logic al,
                                    input logic ex);
        sel_is = (s.store_strobe == st) && (s.ale == al) && (s.ext_access == ex);
    endfunction : sel_is

    // Mode select is a fixed mask choice, no register can flip it
    logic mode1_sel;
    logic mode2_sel;
    assign mode1_sel = !PROTECTED && rst_s2 == MODE1_RST_LVL
                       && sel_is(sel_s2, MODE1_STORE_LVL, MODE1_ALE_LVL, MODE1_EXT_LVL);
    assign mode2_sel = PROTECTED
                       && sel_is(sel_s2, MODE2_STORE_LVL, MODE2_ALE_LVL, MODE2_EXT_LVL);

    // Mode 2 sequencer state; mode is latched while reset is held
    rpv_state_t        state, next_state;
    logic              armed, next_armed;
    logic [1:0]        phase, next_phase;
    logic [ADDR_W-1:0] ptr, next_ptr;
    logic [3:0]        grp, next_grp;
    logic              err, next_err;
    logic              result, next_result;
    logic [DATA_W-1:0] expect0, next_expect0;
    logic              first, next_first;
    logic [ADDR_W-1:0] rom_addr;
    logic [DATA_W-1:0] rom_data;

    rpv_rom u_rom (
        .ref_clk_i (ref_clk_i),
        .addr_i    (rom_addr),
        .data_o    (rom_data)
    );

    // Shared ROM port: mode 2 pointer, mode 1 address, else code fetch
    always_comb begin
        if (state == RPV_RUN) begin
            rom_addr = ptr;
        end else if (mode1_sel) begin
            rom_addr = addr_s2;
        end else begin
            rom_addr = code_move_addr_i;
        end
    end

    // Next-state for the mode 2 walk
    always_comb begin
        logic mismatch;
        mismatch     = 1'b0;
        next_state   = state;
        next_armed   = armed;
        next_phase   = phase;
        next_ptr     = ptr;
        next_grp     = grp;
        next_err     = err;
        next_result  = result;
        next_expect0 = expect0;
        next_first   = first;
        case (state)
            RPV_IDLE: begin
                // Selection levels checked while reset is held
                if (rst_s2) begin
                    next_armed   = mode2_sel;
                    next_expect0 = p0_s2;
                end else if (armed) begin
                    next_state = RPV_RUN;
                    next_phase = 2'h0;
                    next_ptr   = ADDR_START;
                    next_grp   = 4'h0;
                    next_err   = 1'b0;
                    next_first = 1'b1;
                end
            end
            RPV_RUN: begin
                next_phase = (phase == CNT_LAST) ? 2'h0 : phase + 2'h1;
                // Sample slot is the last cycle of each three-clock period
                if (phase == CNT_LAST) begin
                    mismatch   = (first ? expect0 : p0_s2) != rom_data;
                    next_first = 1'b0;
                    if (grp == GRP_LAST) begin
                        next_result = !(err || mismatch);
                        next_err    = 1'b0;
                    end else begin
                        next_err = err || mismatch;
                    end
                    next_grp = grp + 4'h1;
                    if (ptr == ADDR_LAST) begin
                        next_state = RPV_DONE;
                    end else begin
                        next_ptr = ptr + 14'h0001;
                    end
                end
            end
            default: begin
                next_state = RPV_DONE;
            end
        endcase
        if (rst_s2 && state != RPV_IDLE) begin
            next_state = RPV_IDLE;
            next_armed = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            state   <= RPV_IDLE;
            armed   <= 1'b0;
            phase   <= 2'h0;
            ptr     <= ADDR_START;
            grp     <= 4'h0;
            err     <= 1'b0;
            result  <= 1'b1;
            expect0 <= 8'h00;
            first   <= 1'b0;
        end else begin
            state   <= next_state;
            armed   <= next_armed;
            phase   <= next_phase;
            ptr     <= next_ptr;
            grp     <= next_grp;
            err     <= next_err;
            result  <= next_result;
            expect0 <= next_expect0;
            first   <= next_first;
        end
    end

    // Output pins, all registered
    logic [DATA_W-1:0] next_port0;
    logic              next_port0_oe;
    logic              next_ale;
    logic              next_store;
    logic [DATA_W-1:0] next_cm_data;

    always_comb begin
        next_port0    = 8'h00;
        next_port0_oe = 1'b0;
        next_ale      = 1'b0;
        next_store    = 1'b1;
        // Mode 2 never drives ROM onto port 0
        if (mode1_sel && state == RPV_IDLE) begin
            next_port0    = rom_data;
            next_port0_oe = 1'b1;
        end
        if (next_state == RPV_RUN) begin
            next_ale = (next_phase == 2'h0);
        end
        // End of walk marked by store strobe going active
        if (state == RPV_DONE) begin
            next_store = 1'b0;
        end
        // Outside code never sees protected contents
        next_cm_data = (PROTECTED && code_move_ext_i) ? INVALID_BYTE : rom_data;
    end

    always_ff @(posedge ref_clk_i) begin
        // Port 0 pair kept out of reset: mode 1 only runs with reset held high
        port0_o    <= next_port0;
        port0_oe_o <= next_port0_oe;
        if (rst_i) begin
            ale_o                  <= 1'b0;
            program_store_strobe_o <= 1'b1;
            verify_result_pin_o    <= 1'b1;
            code_move_data_o       <= 8'h00;
        end else begin
            ale_o                  <= next_ale;
            program_store_strobe_o <= next_store;
            verify_result_pin_o    <= result;
            code_move_data_o       <= next_cm_data;
        end
    end

    a_no_rom_drive: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        PROTECTED |-> !port0_oe_o) else $error("port 0 driven in protected part");
    a_ale_period: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (ale_o && state == RPV_RUN && ptr != ADDR_LAST) |=> !ale_o ##1 !ale_o ##1 ale_o)
        else $error("strobe period not three clocks");
    a_ptr_step: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == RPV_RUN && phase == CNT_LAST && ptr != ADDR_LAST)
        |=> ptr == $past(ptr) + 14'h0001) else $error("pointer did not step");
    a_err_clear: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == RPV_RUN && phase == CNT_LAST && grp == GRP_LAST) |=> !err)
        else $error("error flag not cleared at group end");
    a_result_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        !(state == RPV_RUN && phase == CNT_LAST && grp == GRP_LAST) |=> $stable(result))
        else $error("result changed mid group");
    a_pin_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        ##1 verify_result_pin_o == $past(result)) else $error("result pin lags");
    a_err_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (err && grp != 4'h0) |=> err || grp == 4'h0) else $error("error lost");
    a_cm_invalid: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (PROTECTED && code_move_ext_i) |=> code_move_data_o == INVALID_BYTE)
        else $error("protected byte leaked");
    a_start_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
        (state == RPV_IDLE && next_state == RPV_RUN) |=> ptr == ADDR_START)
        else $error("walk not starting at zero");
endmodule : rpv_top

//--- src/rpv_pkg.sv
package rpv_pkg;
    localparam int ADDR_W         = 14;
    localparam int DATA_W         = 8;
    localparam int ROM_DEPTH      = 16384;
    // Strobe period in clock periods
    localparam int STROBE_CLP     = 3;
    // Sample delay after strobe rising edge, in clock periods
    localparam int SAMPLE_CLP     = 3;
    localparam int GROUP_BYTES    = 16;
    localparam logic [1:0] CNT_LAST = 2'h2;
    localparam logic [3:0] GRP_LAST = 4'hf;
    localparam logic [13:0] ADDR_LAST = 14'h3fff;
    localparam logic [13:0] ADDR_START = 14'h0000;
    // Byte returned when a protected location is read from outside code
    localparam logic [7:0] INVALID_BYTE = 8'hff;
    // Selection levels for the verify modes
    localparam logic MODE1_STORE_LVL = 1'b0;
    localparam logic MODE1_ALE_LVL   = 1'b0;
    localparam logic MODE1_EXT_LVL   = 1'b1;
    localparam logic MODE1_RST_LVL   = 1'b1;
    localparam logic MODE2_STORE_LVL = 1'b1;
    localparam logic MODE2_ALE_LVL   = 1'b0;
    localparam logic MODE2_EXT_LVL   = 1'b1;

    typedef struct packed {
        logic store_strobe;
        logic ale;
        logic ext_access;
    } rpv_sel_t;

    typedef enum {
        RPV_IDLE,
        RPV_RUN,
        RPV_DONE
    } rpv_state_t;
endpackage : rpv_pkg

//--- src/rpv_rom.sv
module rpv_rom
    import rpv_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    output logic      [DATA_W-1:0] data_o
);
    // Mask contents; zero-filled here, replaced by the mask image flow
    logic [DATA_W-1:0] mem [ROM_DEPTH];
    logic [DATA_W-1:0] rd;

    initial begin
        for (int i = 0; i < ROM_DEPTH; i++) begin
            mem[i] = 8'h00;
        end
    end

    // Registered read: one cycle access delay
    always_ff @(posedge ref_clk_i) begin
        rd <= mem[addr_i];
    end
    assign data_o = rd;
endmodule : rpv_rom

//--- test/rpv_tester.sv
module rpv_tester
    import rpv_pkg::*;
(
    input  wire logic              ref_clk_i,
    input  wire logic              rst_i,
    input  wire logic              ale_i,
    input  wire logic [ADDR_W-1:0] bad_a_i,
    input  wire logic [ADDR_W-1:0] bad_b_i,
    output logic      [DATA_W-1:0] port0_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int unsigned idx;

    // Zero ROM image; listed byte indices get a wrong byte on purpose
    function automatic logic [DATA_W-1:0] expect_byte(input int unsigned i);
        return (i == bad_a_i || i == bad_b_i) ? 8'h5a : 8'h00;
    endfunction : expect_byte

    // Byte 0 sits on the bus through reset, the rest follow the strobes
    always @(negedge ref_clk_i) begin
        if (rst_i) begin
            idx = 0;
            port0_o <= expect_byte(0);
        end else if (ale_i) begin
            port0_o <= expect_byte(idx);
            idx = idx + 1;
        end
    end
endmodule : rpv_tester

//--- test/tb.sv
module tb
    import rpv_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [ADDR_W-1:0] BAD_A = 14'h0010;
    localparam logic [ADDR_W-1:0] BAD_B = 14'h003f;
    localparam int                LIMIT = 60000;
    logic              ref_clk = 1'b0;
    logic              rst_p   = 1'b1;
    logic              rst_u   = 1'b1;
    rpv_sel_t          sel_p   = '{MODE1_STORE_LVL, MODE1_ALE_LVL, MODE1_EXT_LVL};
    rpv_sel_t          sel_u   = '{MODE1_STORE_LVL, MODE1_ALE_LVL, MODE1_EXT_LVL};
    logic [ADDR_W-1:0] test_addr = '0;
    logic [ADDR_W-1:0] cm_addr   = '0;
    logic              cm_ext    = 1'b0;
    logic [15:0]       lfsr      = 16'h001e;
    logic [DATA_W-1:0] p0_in, p0_p, p0_u, cm_p, cm_u;
    logic              oe_p, oe_u, ale_p, ale_u, pss_p, pss_u, res_p, res_u, exp_r;
    int                n_fail = 0, cmp_count = 0, cycles = 0, p = 0, last = 0;

    rpv_top #(.PROTECTED(1'b1)) u_dut (.ref_clk_i(ref_clk), .rst_i(rst_p), .sel_i(sel_p),
        .test_addr_i(test_addr), .port0_i(p0_in), .code_move_ext_i(cm_ext),
        .code_move_addr_i(cm_addr), .port0_o(p0_p), .port0_oe_o(oe_p), .ale_o(ale_p),
        .program_store_strobe_o(pss_p), .verify_result_pin_o(res_p), .code_move_data_o(cm_p));
    rpv_top #(.PROTECTED(1'b0)) u_dut_open (.ref_clk_i(ref_clk), .rst_i(rst_u), .sel_i(sel_u),
        .test_addr_i(test_addr), .port0_i(8'h00), .code_move_ext_i(cm_ext),
        .code_move_addr_i(cm_addr), .port0_o(p0_u), .port0_oe_o(oe_u), .ale_o(ale_u),
        .program_store_strobe_o(pss_u), .verify_result_pin_o(res_u), .code_move_data_o(cm_u));
    rpv_tester u_tester (.ref_clk_i(ref_clk), .rst_i(rst_p), .ale_i(ale_p), .bad_a_i(BAD_A),
        .bad_b_i(BAD_B), .port0_o(p0_in));

    // Free-running clock, also needed by the verify walk
    always #50 ref_clk = ~ref_clk;

    // Hang guard; the full walk needs about 49k cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_fail++;
            final_report();
        end
    end

    function automatic logic [15:0] lfsr_next(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr_next

    // A group passes unless one of the corrupted bytes falls in it
    function automatic logic group_pass(input int g);
        return !((int'(BAD_A) / GROUP_BYTES == g) || (int'(BAD_B) / GROUP_BYTES == g));
    endfunction : group_pass

    task automatic check_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check_byte

    task automatic check_bit(input string what, input logic exp, input logic got);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask : check_bit

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : final_report

    initial begin
        repeat (8) @(negedge ref_clk);
        check_bit("mode1 oe locked", 1'b0, oe_p);
        sel_p = '{MODE2_STORE_LVL, MODE2_ALE_LVL, MODE2_EXT_LVL};
        // Mode 1 reads on the open part at random addresses
        repeat (8) begin
            lfsr = lfsr_next(lfsr);
            test_addr = lfsr[ADDR_W-1:0];
            repeat (6) @(negedge ref_clk);
            check_byte("mode1 data", 8'h00, p0_u);
            check_bit("mode1 oe", 1'b1, oe_u);
        end
        rst_p = 1'b0;
        // Mode 2 walk; result checked early and late in each following group
        while (pss_p === 1'b1 && p <= ROM_DEPTH) begin
            @(negedge ref_clk);
            if (ale_p === 1'b1) begin
                check_bit("mode2 oe", 1'b0, oe_p);
                check_byte("mode2 port0", 8'h00, p0_p);
                if (p > 0) check_bit("ale period", 1'b1, cycles - last == STROBE_CLP);
                if (p % GROUP_BYTES == 2 || p % GROUP_BYTES == 15) begin
                    exp_r = (p < GROUP_BYTES) ? 1'b1 : group_pass(p / GROUP_BYTES - 1);
                    check_bit("result pin", exp_r, res_p);
                end
                last = cycles;
                p++;
            end
        end
        check_bit("walk length", 1'b1, p == ROM_DEPTH);
        check_bit("end strobe", 1'b0, pss_p);
        sel_u = '{MODE2_STORE_LVL, MODE2_ALE_LVL, MODE2_EXT_LVL};
        repeat (4) @(negedge ref_clk);
        rst_u = 1'b0;
        // Code move reads; only the protected part hides its bytes
        repeat (4) begin
            lfsr = lfsr_next(lfsr);
            cm_addr = lfsr[ADDR_W-1:0];
            cm_ext = ~cm_ext;
            repeat (2) @(negedge ref_clk);
            check_byte("cm protected", cm_ext ? INVALID_BYTE : 8'h00, cm_p);
            check_byte("cm open", 8'h00, cm_u);
        end
        // Mode 2 must not start on the open part
        repeat (20) begin
            @(negedge ref_clk);
            check_bit("open ale", 1'b0, ale_u);
            check_bit("open store", 1'b1, pss_u);
            check_bit("open result", 1'b1, res_u);
        end
        final_report();
    end
endmodule : tb
